// ===== logic/sdtg_core.sv
`timescale 1ns/10ps
// Overview of operation
// - reference divided by 6 when ref_ratio_select is 0, by 8 when 1.
// - LO divided by pulse-swallow counter, total ratio M times N plus A.
// - prescaler modulus M is 32 when prescale_select is 0, 34 when 1.
// - main counter N fixed at 32; swallow count A 0..31 from field.
// - pump_override acts on comparator outputs at once, unsynchronised.
// - keying waits for pump state boundary, then holds pump tri-state unless pump_override forces up or down.
// - lock indication high only after 148 us of continuous lock.
// - lock on lock_pin always; on rx_bit_output in synth-only standby.
// - ratio 0 suits a 10.368 MHz reference, 1 suits 13.824 MHz.
// - ramp pin controls the gated amplifier at the selected polarity.
// - amp_enable_delayed is a delayed copy of the ramp pin active state.
// - amp_enable_delayed rises within 200 ns of the ramp pin going active.
// - amp_enable_delayed falls 3 to 6 us after the ramp pin goes inactive.
// - out_power_trim selects -1.3 dB, nominal, +1.3 dB or +1.9 dB.
// - rx_extra_gain selects typically 20 dB or 25 dB front-end gain.
// - pump_override 00 normal, 01 force down, 10 force up, 11 tri-state.
// - ramp pin active high when polarity bit is 1, active low when 0.
// - modulation on by keying flag or keying_pin at selected level.
// - slice hold by freeze flag or level_freeze_pin at selected level.
module sdtg_core #(
   parameter int MAIN_N = sdtg_pkg::SDTG_MAIN_N
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Synthesiser inputs: ticks pulse one cycle per input clock period, phase lock is a level
   input wire logic i_ref_tick,
   input wire logic i_lo_tick,
   input wire logic i_phase_locked,
   // Controller pins
   input wire logic i_keying_pin,
   input wire logic i_level_freeze_pin,
   input wire logic i_tx_ramp_control_pin,
   input wire logic i_slicer_data,
   // Synthesiser outputs
   output logic o_ref_div,
   output logic o_lo_div,
   output logic o_pump_up,
   output logic o_pump_dn,
   output logic o_pump_tri,
   output logic o_lock_pin,
   output logic o_rx_bit_output,
   // Transmit and receive controls
   output logic o_amp_enable_delayed,
   output logic [7:0] o_tx_level,
   output logic [1:0] o_power_trim,
   output logic o_rx_extra_gain,
   output logic o_slice_hold
);
   localparam int RAMP_MAX = sdtg_pkg::SDTG_RAMP_CYC;

   sdtg_pkg::sdtg_synth_t synth_q;
   sdtg_pkg::sdtg_mode_t mode_q;
   sdtg_pkg::sdtg_status_t status;
   logic [31:0] rdata_q;

   // Register writes
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         synth_q <= sdtg_pkg::SDTG_SYNTH_RST;
         mode_q <= sdtg_pkg::SDTG_MODE_RST;
      end else if (i_wr) begin
         if (i_addr == sdtg_pkg::SDTG_OFS_SYNTH) begin
            synth_q <= i_wdata[$bits(sdtg_pkg::sdtg_synth_t)-1:0];
         end
         if (i_addr == sdtg_pkg::SDTG_OFS_MODE) begin
            mode_q <= i_wdata[$bits(sdtg_pkg::sdtg_mode_t)-1:0];
         end
      end
   end

   // Register reads, unmapped addresses read zero
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_q <= 32'h0;
      end else if (i_rd) begin
         case (i_addr)
            sdtg_pkg::SDTG_OFS_SYNTH: rdata_q <= 32'(synth_q);
            sdtg_pkg::SDTG_OFS_MODE: rdata_q <= 32'(mode_q);
            sdtg_pkg::SDTG_OFS_STATUS: rdata_q <= 32'(status);
            default: rdata_q <= 32'h0;
         endcase
      end else begin
         rdata_q <= 32'h0;
      end
   end
   assign o_rdata = rdata_q;

   // Reference divider
   logic [3:0] ref_cnt_q;
   logic [3:0] ref_last;
   logic ref_div_q;
   assign ref_last = synth_q.ref_ratio_select ? 4'(sdtg_pkg::SDTG_REF_DIV_HI - 1)
                                              : 4'(sdtg_pkg::SDTG_REF_DIV_LO - 1);
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ref_cnt_q <= 4'h0;
         ref_div_q <= 1'b0;
      end else begin
         ref_div_q <= 1'b0;
         if (i_ref_tick) begin
            if (ref_cnt_q >= ref_last) begin
               ref_cnt_q <= 4'h0;
               ref_div_q <= 1'b1;
            end else begin
               ref_cnt_q <= ref_cnt_q + 4'h1;
            end
         end
      end
   end
   assign o_ref_div = ref_div_q;

   // Pulse-swallow LO divider: prescaler runs M+1 while swallows remain, else M
   logic [5:0] pre_cnt_q;
   logic [5:0] pre_last;
   logic [5:0] main_cnt_q;
   logic [4:0] swal_q;
   logic lo_div_q;
   always_comb begin
      pre_last = synth_q.prescale_select ? 6'(sdtg_pkg::SDTG_PRESC_TX - 1)
                                         : 6'(sdtg_pkg::SDTG_PRESC_RX - 1);
      if (swal_q != 5'h0) begin
         pre_last = pre_last + 6'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pre_cnt_q <= 6'h0;
         main_cnt_q <= 6'h0;
         swal_q <= 5'h0;
         lo_div_q <= 1'b0;
      end else begin
         lo_div_q <= 1'b0;
         if (i_lo_tick) begin
            if (pre_cnt_q >= pre_last) begin
               pre_cnt_q <= 6'h0;
               if (main_cnt_q >= 6'(MAIN_N - 1)) begin
                  main_cnt_q <= 6'h0;
                  swal_q <= synth_q.swallow_count;
                  lo_div_q <= 1'b1;
               end else begin
                  main_cnt_q <= main_cnt_q + 6'h1;
                  if (swal_q != 5'h0) begin
                     swal_q <= swal_q - 5'h1;
                  end
               end
            end else begin
               pre_cnt_q <= pre_cnt_q + 6'h1;
            end
         end
      end
   end
   assign o_lo_div = lo_div_q;

   // Three-state phase-frequency comparator
   logic up_q;
   logic dn_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         if ((up_q || ref_div_q) && (dn_q || lo_div_q)) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
         end else begin
            up_q <= up_q || ref_div_q;
            dn_q <= dn_q || lo_div_q;
         end
      end
   end

   // Keying hold only engages when the pump sits between pulses
   logic keying_on;
   logic hold_q;
   assign keying_on = mode_q.fm_keying_enable ||
                      (i_keying_pin == mode_q.keying_pin_polarity);
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_q <= 1'b0;
      end else if (!keying_on) begin
         hold_q <= 1'b0;
      end else if (!up_q && !dn_q) begin
         hold_q <= 1'b1;
      end
   end

   // Override is combinational so a change reaches the pump in the same cycle
   always_comb begin
      o_pump_up = 1'b0;
      o_pump_dn = 1'b0;
      o_pump_tri = 1'b0;
      case (mode_q.pump_override)
         sdtg_pkg::SDTG_PUMP_NORMAL: begin
            o_pump_up = up_q && !hold_q;
            o_pump_dn = dn_q && !hold_q;
            o_pump_tri = hold_q || (up_q == dn_q);
         end
         sdtg_pkg::SDTG_PUMP_FORCE_DN: o_pump_dn = 1'b1;
         sdtg_pkg::SDTG_PUMP_FORCE_UP: o_pump_up = 1'b1;
         sdtg_pkg::SDTG_PUMP_TRI: o_pump_tri = 1'b1;
         default: o_pump_tri = 1'b1;
      endcase
   end

   // Lock qualification
   logic [10:0] lock_cnt_q;
   logic lock_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lock_cnt_q <= 11'h0;
         lock_q <= 1'b0;
      end else if (!i_phase_locked) begin
         lock_cnt_q <= 11'h0;
         lock_q <= 1'b0;
      end else if (lock_cnt_q >= 11'(sdtg_pkg::SDTG_LOCK_CYC - 1)) begin
         lock_q <= 1'b1;
      end else begin
         lock_cnt_q <= lock_cnt_q + 11'h1;
      end
   end

   logic rx_bit_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_bit_q <= 1'b0;
      end else if (mode_q.synth_power && !mode_q.front_end_power &&
                   !mode_q.transmit_power_on) begin
         rx_bit_q <= lock_q;
      end else begin
         rx_bit_q <= i_slicer_data;
      end
   end
   assign o_lock_pin = lock_q;
   assign o_rx_bit_output = rx_bit_q;

   // Transmit gating
   logic gate_on;
   logic [1:0] on_cnt_q;
   logic [5:0] off_cnt_q;
   logic amp_q;
   logic [7:0] ramp_q;
   assign gate_on = (i_tx_ramp_control_pin == mode_q.ramp_pin_polarity);

   // Amplifier enable rises with the first ramp step and trails the ramp down
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         on_cnt_q <= 2'h0;
         off_cnt_q <= 6'h0;
         amp_q <= 1'b0;
      end else if (gate_on) begin
         off_cnt_q <= 6'h0;
         if (on_cnt_q >= 2'(sdtg_pkg::SDTG_PA_ON_CYC - 1)) begin
            amp_q <= 1'b1;
         end else begin
            on_cnt_q <= on_cnt_q + 2'h1;
         end
      end else begin
         on_cnt_q <= 2'h0;
         if (amp_q) begin
            if (off_cnt_q >= 6'(sdtg_pkg::SDTG_PA_OFF_CYC - 1)) begin
               amp_q <= 1'b0;
               off_cnt_q <= 6'h0;
            end else begin
               off_cnt_q <= off_cnt_q + 6'h1;
            end
         end
      end
   end
   assign o_amp_enable_delayed = amp_q;

   // Linear output ramp, full scale RAMP_MAX
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ramp_q <= 8'h0;
      end else if (gate_on && ramp_q < 8'(RAMP_MAX)) begin
         ramp_q <= ramp_q + 8'h1;
      end else if (!gate_on && ramp_q != 8'h0) begin
         ramp_q <= ramp_q - 8'h1;
      end
   end
   assign o_tx_level = ramp_q;

   // Trim, gain and slice hold
   logic slice_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         slice_q <= 1'b0;
      end else begin
         slice_q <= mode_q.level_freeze_enable ||
                    (i_level_freeze_pin == mode_q.level_freeze_polarity);
      end
   end
   assign o_slice_hold = slice_q;
   assign o_power_trim = synth_q.out_power_trim;
   assign o_rx_extra_gain = synth_q.rx_extra_gain;

   always_comb begin
      status.locked = lock_q;
      status.pump_held = hold_q;
      status.amp_enable = amp_q;
      status.slice_hold = slice_q;
      status.tx_gate_active = gate_on;
   end
endmodule : sdtg_core

// ===== logic/sdtg_pkg.sv
package sdtg_pkg;
   // Register byte offsets
   localparam logic [3:0] SDTG_OFS_SYNTH = 4'h0;
   localparam logic [3:0] SDTG_OFS_MODE = 4'h4;
   localparam logic [3:0] SDTG_OFS_STATUS = 4'h8;

   // Divider ratios
   localparam int SDTG_REF_DIV_LO = 6;
   localparam int SDTG_REF_DIV_HI = 8;
   localparam int SDTG_PRESC_RX = 32;
   localparam int SDTG_PRESC_TX = 34;
   localparam int SDTG_MAIN_N = 32;

   // Timing, clock at 10 MHz
   localparam int SDTG_CLK_HZ = 10000000;
   localparam int SDTG_LOCK_US = 148;
   localparam int SDTG_LOCK_CYC = (SDTG_LOCK_US * (SDTG_CLK_HZ / 1000000));
   localparam int SDTG_PA_ON_NS = 100;
   localparam int SDTG_PA_ON_CYC = (SDTG_PA_ON_NS * (SDTG_CLK_HZ / 1000000) + 999) / 1000;
   localparam int SDTG_PA_OFF_NS = 4000;
   localparam int SDTG_PA_OFF_CYC = (SDTG_PA_OFF_NS * (SDTG_CLK_HZ / 1000000)) / 1000;
   localparam int SDTG_RAMP_NS = 2000;
   localparam int SDTG_RAMP_CYC = (SDTG_RAMP_NS * (SDTG_CLK_HZ / 1000000)) / 1000;

   // Pump override codes
   localparam logic [1:0] SDTG_PUMP_NORMAL = 2'h0;
   localparam logic [1:0] SDTG_PUMP_FORCE_DN = 2'h1;
   localparam logic [1:0] SDTG_PUMP_FORCE_UP = 2'h2;
   localparam logic [1:0] SDTG_PUMP_TRI = 2'h3;

   // Power trim codes
   localparam logic [1:0] SDTG_TRIM_M13 = 2'h0;
   localparam logic [1:0] SDTG_TRIM_NOM = 2'h1;
   localparam logic [1:0] SDTG_TRIM_P13 = 2'h2;
   localparam logic [1:0] SDTG_TRIM_P19 = 2'h3;

   typedef struct packed {
      logic rx_extra_gain;
      logic [1:0] out_power_trim;
      logic ref_ratio_select;
      logic prescale_select;
      logic [4:0] swallow_count;
   } sdtg_synth_t;

   typedef struct packed {
      logic [1:0] pump_override;
      logic ramp_pin_polarity;
      logic fm_keying_enable;
      logic keying_pin_polarity;
      logic level_freeze_enable;
      logic level_freeze_polarity;
      logic transmit_power_on;
      logic front_end_power;
      logic synth_power;
   } sdtg_mode_t;

   typedef struct packed {
      logic tx_gate_active;
      logic slice_hold;
      logic amp_enable;
      logic pump_held;
      logic locked;
   } sdtg_status_t;

   localparam sdtg_synth_t SDTG_SYNTH_RST = '0;
   localparam sdtg_mode_t SDTG_MODE_RST = '0;
endpackage : sdtg_pkg

// ===== test/sdtg_core_properties.sv
`timescale 1ns/10ps
module sdtg_core_properties #(
   parameter int MAIN_N = sdtg_pkg::SDTG_MAIN_N
) (
   // Clock, reset and register writes
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   // Pins from the controller
   input wire logic i_phase_locked,
   input wire logic i_keying_pin,
   input wire logic i_level_freeze_pin,
   input wire logic i_tx_ramp_control_pin,
   // Outputs watched
   input wire logic o_pump_up,
   input wire logic o_pump_dn,
   input wire logic o_pump_tri,
   input wire logic o_lock_pin,
   input wire logic o_rx_bit_output,
   input wire logic o_amp_enable_delayed,
   input wire logic o_slice_hold
);
   sdtg_pkg::sdtg_mode_t mode_q;
   logic [6:0] off_q;
   logic [10:0] lock_q;
   logic gate_on;
   logic key_on;
   logic frz_on;
   logic stby;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   assign gate_on = i_tx_ramp_control_pin == mode_q.ramp_pin_polarity;
   assign key_on = mode_q.fm_keying_enable | (i_keying_pin == mode_q.keying_pin_polarity);
   assign frz_on = mode_q.level_freeze_enable |
                   (i_level_freeze_pin == mode_q.level_freeze_polarity);
   assign stby = mode_q.synth_power & ~mode_q.front_end_power & ~mode_q.transmit_power_on;
   // Shadow of the mode word, so no peeking inside the design
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_q <= '0;
      end else if (i_wr && i_addr == 4'h4) begin
         mode_q <= i_wdata[9:0];
      end
   end
   // Saturating counters: cycles since gate off, cycles of unbroken lock
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         off_q <= 7'h0;
         lock_q <= 11'h0;
      end else begin
         off_q <= gate_on ? 7'h0 : off_q + {6'h0, off_q != 7'h7F};
         lock_q <= i_phase_locked ? lock_q + {10'h0, lock_q != 11'h7FF} : 11'h0;
      end
   end
   // Keying may wait for an idle pump; once idle under keying it must stay parked
   sequence key_s;
      (key_on && mode_q.pump_override == 2'h0 && o_pump_tri && !o_pump_up && !o_pump_dn)
         ##1 (mode_q.pump_override == 2'h0);
   endsequence
   sequence ovr_s;
      (!key_on && mode_q.pump_override != 2'h0) [*3];
   endsequence
   amp_rise_a: assert property ($rose(gate_on) |-> ##[1:2] o_amp_enable_delayed)
      else $error("amp enable late");
   amp_fall_a: assert property ($fell(o_amp_enable_delayed) |->
      off_q inside {[7'h1E:7'h3D]})
      else $error("amp enable dropped outside window");
   amp_drop_a: assert property (off_q == 7'h3E |-> !o_amp_enable_delayed)
      else $error("amp enable held too long");
   lock_hold_a: assert property (o_lock_pin |-> lock_q >= 11'h5C8)
      else $error("lock shown too early");
   lock_set_a: assert property (lock_q == 11'h5C9 |-> o_lock_pin)
      else $error("lock not shown");
   lock_drop_a: assert property (!i_phase_locked |=> !o_lock_pin)
      else $error("lock kept after loss");
   rx_lock_a: assert property (stby && $past(stby) && $stable(o_lock_pin) |->
      o_rx_bit_output == o_lock_pin)
      else $error("rx output not lock in standby");
   pump_ovr_a: assert property (ovr_s |->
      (mode_q.pump_override == 2'h3 ? o_pump_tri
                                    : ({o_pump_up, o_pump_dn} == mode_q.pump_override)))
      else $error("pump override wrong");
   key_hold_a: assert property (key_s |->
      o_pump_tri && !o_pump_up && !o_pump_dn)
      else $error("pump not held for keying");
   slice_a: assert property ($past(i_arst_n) |-> o_slice_hold == $past(frz_on))
      else $error("slice hold wrong");
endmodule : sdtg_core_properties

bind sdtg_core sdtg_core_properties #(.MAIN_N(MAIN_N)) u_props (
   .i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_phase_locked, .i_keying_pin,
   .i_level_freeze_pin, .i_tx_ramp_control_pin, .o_pump_up, .o_pump_dn, .o_pump_tri,
   .o_lock_pin, .o_rx_bit_output, .o_amp_enable_delayed, .o_slice_hold
);

// ===== test/sdtg_ctrl_model.sv
`timescale 1ns/10ps
module sdtg_ctrl_model (
   // Wanted states and pin polarities: gate, freeze, keying
   input wire logic i_gate_on,
   input wire logic i_freeze_on,
   input wire logic i_key_on,
   input wire logic [2:0] i_pol,
   // Pins towards the device
   output logic o_ref_tick,
   output logic o_lo_tick,
   output logic o_ramp_pin,
   output logic o_freeze_pin,
   output logic o_key_pin
);
   // Ticks every cycle: fastest legal rate keeps the run short
   assign o_ref_tick = 1'b1;
   assign o_lo_tick = 1'b1;
   assign o_ramp_pin = i_gate_on ~^ i_pol[2];
   assign o_freeze_pin = i_freeze_on ~^ i_pol[1];
   assign o_key_pin = i_key_on ~^ i_pol[0];
endmodule : sdtg_ctrl_model

// ===== test/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_phase_locked = 1'b0;
   logic i_slicer_data = 1'b0;
   logic gate_on = 1'b0;
   logic freeze_on = 1'b0;
   logic key_on = 1'b0;
   logic [2:0] pol = 3'h0;
   logic ref_tick, lo_tick, ramp_pin, freeze_pin, key_pin;
   logic [31:0] o_rdata;
   logic o_ref_div, o_lo_div, o_pump_up, o_pump_dn, o_pump_tri, o_lock_pin, o_rx_bit_output;
   logic o_amp_enable_delayed, o_rx_extra_gain, o_slice_hold;
   logic [7:0] o_tx_level;
   logic [1:0] o_power_trim;
   sdtg_pkg::sdtg_mode_t mode;
   int bad_count = 0;
   int checks = 0;
   int n;
   always #50 i_clk = ~i_clk;
   sdtg_ctrl_model ctrl (
      .i_gate_on(gate_on), .i_freeze_on(freeze_on), .i_key_on(key_on), .i_pol(pol),
      .o_ref_tick(ref_tick), .o_lo_tick(lo_tick), .o_ramp_pin(ramp_pin),
      .o_freeze_pin(freeze_pin), .o_key_pin(key_pin)
   );
   sdtg_core dut (
      .i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_ref_tick(ref_tick), .i_lo_tick(lo_tick), .i_phase_locked,
      .i_keying_pin(key_pin), .i_level_freeze_pin(freeze_pin),
      .i_tx_ramp_control_pin(ramp_pin), .i_slicer_data, .o_ref_div, .o_lo_div,
      .o_pump_up, .o_pump_dn, .o_pump_tri, .o_lock_pin, .o_rx_bit_output,
      .o_amp_enable_delayed, .o_tx_level, .o_power_trim, .o_rx_extra_gain, .o_slice_hold
   );
   task automatic complete_run;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd
   // Pin polarities follow the mode word on the edge at which it lands
   task automatic md(input sdtg_pkg::sdtg_mode_t m);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= 4'h4;
      i_wdata <= {22'h0, m};
      @(posedge i_clk);
      i_wr <= 1'b0;
      pol <= {m.ramp_pin_polarity, m.level_freeze_polarity, m.keying_pin_polarity};
      #1;
   endtask : md
   // Cycles between two divider pulses; the first pulse found only aligns
   task automatic period(input bit lo, output int p);
      repeat (2) begin
         n = 0;
         do begin
            @(posedge i_clk);
            #1 n++;
         end while ((lo ? o_lo_div : o_ref_div) !== 1'b1 && n < 1200);
      end
      p = n;
   endtask : period
   initial begin
      #4000000;
      bad_count++;
      complete_run();
   end
   initial begin
      logic [31:0] d;
      int p;
      int e;
      repeat (3) @(posedge i_clk);
      i_arst_n <= 1'b1;
      wr(4'h8, 32'hFFFF_FFFF);
      for (int a = 0; a < 16; a += 4) begin
         rd(a[3:0], d);
         chk("reset read", 32'h0, d);
      end
      for (int t = 0; t < 4; t++) begin
         wr(4'h0, {22'h0, t[0], t[1:0], 7'h0});
         chk("trim", {30'h0, t[1:0]}, {30'h0, o_power_trim});
         chk("gain", {31'h0, t[0]}, {31'h0, o_rx_extra_gain});
      end
      for (int c = 0; c < 4; c++) begin
         wr(4'h0, {25'h0, c[0], c[1], c[0] ? 5'h1F : 5'h00});
         period(1'b0, p);
         e = c[0] ? sdtg_pkg::SDTG_REF_DIV_HI : sdtg_pkg::SDTG_REF_DIV_LO;
         chk("ref period", e, p);
         period(1'b1, p);
         e = c[1] ? sdtg_pkg::SDTG_PRESC_TX : sdtg_pkg::SDTG_PRESC_RX;
         e = e * sdtg_pkg::SDTG_MAIN_N + (c[0] ? 31 : 0);
         chk("lo period", e, p);
      end
      for (int k = 1; k < 4; k++) begin
         mode = '0;
         mode.pump_override = k[1:0];
         md(mode);
         e = {29'h0, k == 2, k == 1, k == 3};
         chk("pump", e, {29'h0, o_pump_up, o_pump_dn, o_pump_tri});
      end
      for (int k = 0; k < 2; k++) begin
         mode = '0;
         mode.fm_keying_enable = k[0];
         md(mode);
         @(posedge i_clk);
         key_on <= ~k[0];
         // The hold waits for an idle pump, which comes only just after an LO pulse
         n = 0;
         do begin
            @(posedge i_clk);
            #1 n++;
         end while ({o_pump_up, o_pump_dn, o_pump_tri} !== 3'h1 && n < 1200);
         // Long enough for a reference pulse, which would show if the hold failed
         repeat (10) @(posedge i_clk);
         #1 chk("key hold", 32'h1, {29'h0, o_pump_up, o_pump_dn, o_pump_tri});
         @(posedge i_clk);
         key_on <= 1'b0;
      end
      mode = '0;
      mode.synth_power = 1'b1;
      md(mode);
      @(posedge i_clk);
      i_phase_locked <= 1'b1;
      repeat (1470) @(posedge i_clk);
      #1 chk("early lock", 32'h0, {31'h0, o_lock_pin});
      repeat (20) @(posedge i_clk);
      #1 chk("lock", 32'h3, {30'h0, o_lock_pin, o_rx_bit_output});
      mode.front_end_power = 1'b1;
      md(mode);
      repeat (3) @(posedge i_clk);
      #1 chk("rx data", 32'h2, {30'h0, o_lock_pin, o_rx_bit_output});
      mode.front_end_power = 1'b0;
      mode.transmit_power_on = 1'b1;
      md(mode);
      repeat (3) @(posedge i_clk);
      #1 chk("rx tx data", 32'h2, {30'h0, o_lock_pin, o_rx_bit_output});
      @(posedge i_clk);
      i_phase_locked <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 chk("lock lost", 32'h0, {31'h0, o_lock_pin});
      for (int k = 0; k < 2; k++) begin
         mode = '0;
         mode.ramp_pin_polarity = k[0];
         md(mode);
         @(posedge i_clk);
         gate_on <= 1'b1;
         repeat (2) @(posedge i_clk);
         #1 chk("amp on", 32'h1, 32'(o_amp_enable_delayed));
         repeat (25) @(posedge i_clk);
         #1 chk("ramp up", 32'h14, {24'h0, o_tx_level});
         @(posedge i_clk);
         gate_on <= 1'b0;
         repeat (25) @(posedge i_clk);
         #1 e = {23'h0, o_amp_enable_delayed, o_tx_level};
         chk("ramp down", 32'h100, e);
         repeat (40) @(posedge i_clk);
         #1 chk("amp off", 32'h0, {31'h0, o_amp_enable_delayed});
      end
      for (int k = 0; k < 3; k++) begin
         mode = '0;
         mode.level_freeze_polarity = k[0];
         mode.level_freeze_enable = k[1];
         md(mode);
         @(posedge i_clk);
         freeze_on <= ~k[1];
         repeat (2) @(posedge i_clk);
         #1 chk("slice hold", 32'h1, {31'h0, o_slice_hold});
         rd(4'h8, d);
         chk("status", 32'h8, d);
         @(posedge i_clk);
         freeze_on <= 1'b0;
         repeat (2) @(posedge i_clk);
         #1 chk("slice free", {31'h0, k[1]}, {31'h0, o_slice_hold});
      end
      complete_run();
   end
endmodule : testbench
